// *** design/afe_cfg.svh ***
`ifndef AFE_CFG_SVH
`define AFE_CFG_SVH

// register indices, byte address is four times the index
`define AFE_IDX_SYS 3'h0
`define AFE_IDX_INPUT 3'h1
`define AFE_IDX_GAIN 3'h2
`define AFE_IDX_SPARE 3'h3
`define AFE_IDX_SHIFT 3'h4
`define AFE_IDX_REF 3'h5
`define AFE_IDX_STATUS 3'h6
`define AFE_NREG 6

// reset values
`define AFE_RST_SYS 8'h00
`define AFE_RST_INPUT 8'h00
`define AFE_RST_GAIN 8'h00
`define AFE_RST_SPARE 8'h00
`define AFE_RST_SHIFT 8'h00
`define AFE_RST_REF 8'h40

// system_config fields
`define AFE_MSEL_HI 7
`define AFE_MSEL_LO 6
`define AFE_WMODE_HI 5
`define AFE_WMODE_LO 4
`define AFE_VREF_BIT 3
`define AFE_CONV_BIT 2
`define AFE_REGU_BIT 1

// input_config fields
`define AFE_BOOST_BIT 7
`define AFE_SRATE_BIT 6
`define AFE_NEG_HI 5
`define AFE_NEG_LO 3
`define AFE_POS_HI 2
`define AFE_POS_LO 0

// gain_rate_config fields
`define AFE_ORATE_HI 7
`define AFE_ORATE_LO 5
`define AFE_BYPASS_BIT 4
`define AFE_AGAIN_HI 3
`define AFE_AGAIN_LO 2
`define AFE_MGAIN_HI 1
`define AFE_MGAIN_LO 0

// level shift and reference fields
`define AFE_LSHIFT_BIT 2
`define AFE_REFSEL_HI 3
`define AFE_REFSEL_LO 2

// mode codes
`define AFE_MSEL_SUPPLY 2'h2
`define AFE_MSEL_MANUAL 2'h0
`define AFE_WMODE_FREE 2'h3
`define AFE_WMODE_DUTY 2'h2
`define AFE_WMODE_HIPERF 2'h1
`define AFE_WMODE_COMMON 2'h0

// forced values
`define AFE_SUP_INSEL 3'h4
`define AFE_SUP_REFSEL 2'h2
`define AFE_DUTY_ORATE 3'h6

// timing
`define AFE_CLK_HZ 100000000
`define AFE_DUTY_RATE_HZ 640
`define AFE_DUTY_ON_US 200

`endif

// *** design/afe_cfg_regs.sv ***
// Operation
// - three config registers at 0x00-0x02, read/write
// - measurement_select: 10 supply, 00 manual
// - supply mode forces listed effective settings
// - work_mode applies only in manual, 11 free
// - duty mode: 640Hz, forced bits, own power control
// - high-performance forces rate 1, bypass 0, boost 1
// - common mode forces rate 0, bypass 1, boost 0
// - system bit 3 enables voltage reference
// - system bit 2 enables converter
// - system bit 1 enables regulator, bit 0 spare
// - input bit 7 doubles modulator current
// - input bit 6 selects 662.22 or 331.11 kHz
// - input bits 5:3 select negative input
// - input bits 2:0 select positive input
// - gain/rate bits 7:5 select output rate
// - gain/rate bit 4 bypasses input buffer
// - gain/rate bits 3:2 set amplifier gain
// - gain/rate bits 1:0 set modulator gain
// - register 0x03 is plain spare storage
// - level_shift_enable kept in separate register
// - reference_select kept in separate register
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "afe_cfg.svh"

module afe_cfg_regs
  import afe_pkg::*;
#(
  parameter int unsigned DUTY_PERIOD_CYC = `AFE_CLK_HZ / `AFE_DUTY_RATE_HZ,
  parameter int unsigned DUTY_ON_CYC = (`AFE_CLK_HZ / 1000000) * `AFE_DUTY_ON_US
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // effective analog settings
  output afe_analog_t analog_o
);

  localparam logic [7:0] RST_VAL [0:`AFE_NREG-1] = '{
    `AFE_RST_SYS, `AFE_RST_INPUT, `AFE_RST_GAIN,
    `AFE_RST_SPARE, `AFE_RST_SHIFT, `AFE_RST_REF
  };

  afe_req_t req;
  logic [7:0] cfg_reg [0:`AFE_NREG-1];
  logic [7:0] rdata;
  logic [7:0] status;
  logic [1:0] msel;
  logic [1:0] wmode;
  logic supply_mode;
  logic duty_mode;
  logic duty_power;
  afe_analog_t analog_next;

  afe_wb_slave u_bus (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .req_o(req),
    .rdata_i(rdata)
  );

  // plain storage, stored bits never see the mode overrides
  generate
    for (genvar g = 0; g < `AFE_NREG; g++) begin : g_store
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cfg_reg[g] <= RST_VAL[g];
        end else if (req.wr && (req.idx == 3'(g))) begin
          cfg_reg[g] <= req.wdata;
        end
      end
    end
  endgenerate

  assign msel = cfg_reg[`AFE_IDX_SYS][`AFE_MSEL_HI:`AFE_MSEL_LO];
  assign wmode = cfg_reg[`AFE_IDX_SYS][`AFE_WMODE_HI:`AFE_WMODE_LO];
  assign supply_mode = (msel == `AFE_MSEL_SUPPLY);
  assign duty_mode = (msel == `AFE_MSEL_MANUAL) && (wmode == `AFE_WMODE_DUTY);

  afe_duty_seq #(
    .PERIOD_CYC(DUTY_PERIOD_CYC),
    .ON_CYC(DUTY_ON_CYC)
  ) u_duty (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(duty_mode),
    .power_o(duty_power)
  );

  assign status = {5'h0, duty_mode, supply_mode, duty_power};

  // readback, bits 0 and the spare register are plain storage
  always_comb begin
    rdata = 8'h00;
    if (!req.hit) begin
      rdata = 8'h00;
    end else if (req.idx == `AFE_IDX_STATUS) begin
      rdata = status;
    end else if (req.idx < 3'(`AFE_NREG)) begin
      rdata = cfg_reg[req.idx];
    end
  end

  always_comb begin
    analog_next.vref_enable = cfg_reg[`AFE_IDX_SYS][`AFE_VREF_BIT];
    analog_next.converter_enable = cfg_reg[`AFE_IDX_SYS][`AFE_CONV_BIT];
    analog_next.regulator_enable = cfg_reg[`AFE_IDX_SYS][`AFE_REGU_BIT];
    analog_next.modulator_current_boost = cfg_reg[`AFE_IDX_INPUT][`AFE_BOOST_BIT];
    analog_next.sample_rate_select = cfg_reg[`AFE_IDX_INPUT][`AFE_SRATE_BIT];
    analog_next.neg_input_select = cfg_reg[`AFE_IDX_INPUT][`AFE_NEG_HI:`AFE_NEG_LO];
    analog_next.pos_input_select = cfg_reg[`AFE_IDX_INPUT][`AFE_POS_HI:`AFE_POS_LO];
    analog_next.output_rate_select = cfg_reg[`AFE_IDX_GAIN][`AFE_ORATE_HI:`AFE_ORATE_LO];
    analog_next.buffer_bypass = cfg_reg[`AFE_IDX_GAIN][`AFE_BYPASS_BIT];
    analog_next.amp_gain = cfg_reg[`AFE_IDX_GAIN][`AFE_AGAIN_HI:`AFE_AGAIN_LO];
    analog_next.modulator_gain = cfg_reg[`AFE_IDX_GAIN][`AFE_MGAIN_HI:`AFE_MGAIN_LO];
    analog_next.level_shift_enable = cfg_reg[`AFE_IDX_SHIFT][`AFE_LSHIFT_BIT];
    analog_next.reference_select = cfg_reg[`AFE_IDX_REF][`AFE_REFSEL_HI:`AFE_REFSEL_LO];
    if (supply_mode) begin
      analog_next.vref_enable = 1'b1;
      analog_next.pos_input_select = `AFE_SUP_INSEL;
      analog_next.neg_input_select = `AFE_SUP_INSEL;
      analog_next.level_shift_enable = 1'b0;
      analog_next.amp_gain = 2'h0;
      analog_next.buffer_bypass = 1'b0;
      analog_next.modulator_gain = 2'h0;
      analog_next.reference_select = `AFE_SUP_REFSEL;
      analog_next.sample_rate_select = 1'b0;
      analog_next.modulator_current_boost = 1'b0;
    end else if (msel == `AFE_MSEL_MANUAL) begin
      case (wmode)
        `AFE_WMODE_DUTY: begin
          analog_next.output_rate_select = `AFE_DUTY_ORATE;
          analog_next.sample_rate_select = 1'b0;
          analog_next.buffer_bypass = 1'b0;
          analog_next.modulator_current_boost = 1'b0;
          analog_next.converter_enable = duty_power;
          analog_next.regulator_enable = duty_power;
        end
        `AFE_WMODE_HIPERF: begin
          analog_next.sample_rate_select = 1'b1;
          analog_next.buffer_bypass = 1'b0;
          analog_next.modulator_current_boost = 1'b1;
        end
        `AFE_WMODE_COMMON: begin
          analog_next.sample_rate_select = 1'b0;
          analog_next.buffer_bypass = 1'b1;
          analog_next.modulator_current_boost = 1'b0;
        end
        default: begin
          analog_next.sample_rate_select = analog_next.sample_rate_select;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_o <= '0;
    end else begin
      analog_o <= analog_next;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_wr_store;
    req.wr && (req.idx == `AFE_IDX_SYS) |=> cfg_reg[`AFE_IDX_SYS] == $past(wb_dat_i[7:0]);
  endproperty
  a_wr_store: assert property (p_wr_store) else $error("system write not stored");

  property p_rdback;
    wb_ack_o && !wb_we_i && (wb_adr_i == 8'h04) |-> wb_dat_o == {24'h0, $past(cfg_reg[1])};
  endproperty
  a_rdback: assert property (p_rdback) else $error("input readback wrong");

  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held over two cycles");

  property p_supply;
    supply_mode |=> analog_o.vref_enable && analog_o.pos_input_select == 3'h4
      && analog_o.neg_input_select == 3'h4 && analog_o.reference_select == 2'h2
      && !analog_o.level_shift_enable && analog_o.amp_gain == 2'h0
      && !analog_o.modulator_current_boost && !analog_o.sample_rate_select;
  endproperty
  a_supply: assert property (p_supply) else $error("supply overrides missing");

  property p_free;
    msel == 2'h0 && wmode == 2'h3 |=>
      analog_o.sample_rate_select == $past(cfg_reg[1][6])
      && analog_o.buffer_bypass == $past(cfg_reg[2][4]);
  endproperty
  a_free: assert property (p_free) else $error("free mode not from registers");

  property p_duty;
    duty_mode |=> analog_o.output_rate_select == 3'h6
      && analog_o.converter_enable == $past(duty_power);
  endproperty
  a_duty: assert property (p_duty) else $error("duty mode settings wrong");

  property p_hiperf;
    msel == 2'h0 && wmode == 2'h1 |=> analog_o.sample_rate_select
      && analog_o.modulator_current_boost && !analog_o.buffer_bypass;
  endproperty
  a_hiperf: assert property (p_hiperf) else $error("high performance wrong");

  property p_common;
    !rst_i && msel == 2'h0 && wmode == 2'h0 |=> !analog_o.sample_rate_select
      && analog_o.buffer_bypass && !analog_o.modulator_current_boost;
  endproperty
  a_common: assert property (p_common) else $error("common mode wrong");

  property p_vref;
    !supply_mode |=> analog_o.vref_enable == $past(cfg_reg[0][3]);
  endproperty
  a_vref: assert property (p_vref) else $error("reference enable wrong");

  property p_rst_zero;
    $fell(rst_i) |-> cfg_reg[0] == 8'h00 && cfg_reg[1] == 8'h00
      && cfg_reg[2] == 8'h00 && cfg_reg[3] == 8'h00;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("registers not zero after reset");

  property p_rst_analog;
    $fell(rst_i) |-> analog_o == '0;
  endproperty
  a_rst_analog: assert property (p_rst_analog) else $error("settings not zero after reset");

  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("request not acknowledged");

  property p_spare_store;
    req.wr && (req.idx == `AFE_IDX_SPARE) |=> cfg_reg[`AFE_IDX_SPARE] == $past(wb_dat_i[7:0]);
  endproperty
  a_spare_store: assert property (p_spare_store) else $error("spare write not stored");

  property p_keep;
    !(req.wr && (req.idx == `AFE_IDX_SYS)) |=>
      cfg_reg[`AFE_IDX_SYS] == $past(cfg_reg[`AFE_IDX_SYS]);
  endproperty
  a_keep: assert property (p_keep) else $error("stored system bits changed");

  property p_conv;
    !duty_mode |=> analog_o.converter_enable == $past(cfg_reg[0][2]);
  endproperty
  a_conv: assert property (p_conv) else $error("converter enable wrong");

  property p_regu;
    !duty_mode |=> analog_o.regulator_enable == $past(cfg_reg[0][1]);
  endproperty
  a_regu: assert property (p_regu) else $error("regulator enable wrong");

  property p_boost;
    !supply_mode && (msel != 2'h0 || wmode == 2'h3) |=>
      analog_o.modulator_current_boost == $past(cfg_reg[1][7]);
  endproperty
  a_boost: assert property (p_boost) else $error("current boost not from register");

  property p_srate;
    !supply_mode && (msel != 2'h0 || wmode == 2'h3) |=>
      analog_o.sample_rate_select == $past(cfg_reg[1][6]);
  endproperty
  a_srate: assert property (p_srate) else $error("sampling rate not from register");

  property p_neg;
    !supply_mode |=> analog_o.neg_input_select == $past(cfg_reg[1][5:3]);
  endproperty
  a_neg: assert property (p_neg) else $error("negative input wrong");

  property p_pos;
    !supply_mode |=> analog_o.pos_input_select == $past(cfg_reg[1][2:0]);
  endproperty
  a_pos: assert property (p_pos) else $error("positive input wrong");

  property p_orate;
    !duty_mode |=> analog_o.output_rate_select == $past(cfg_reg[2][7:5]);
  endproperty
  a_orate: assert property (p_orate) else $error("output rate wrong");

  property p_bypass;
    !supply_mode && (msel != 2'h0 || wmode == 2'h3) |=>
      analog_o.buffer_bypass == $past(cfg_reg[2][4]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("buffer bypass not from register");

  property p_again;
    !supply_mode |=> analog_o.amp_gain == $past(cfg_reg[2][3:2]);
  endproperty
  a_again: assert property (p_again) else $error("amplifier gain wrong");

  property p_mgain;
    !supply_mode |=> analog_o.modulator_gain == $past(cfg_reg[2][1:0]);
  endproperty
  a_mgain: assert property (p_mgain) else $error("modulator gain wrong");

  property p_lshift;
    !supply_mode |=> analog_o.level_shift_enable == $past(cfg_reg[4][2]);
  endproperty
  a_lshift: assert property (p_lshift) else $error("level shift wrong");

  property p_refsel;
    !supply_mode |=> analog_o.reference_select == $past(cfg_reg[5][3:2]);
  endproperty
  a_refsel: assert property (p_refsel) else $error("reference select wrong");

  property p_sup_rest;
    supply_mode |=> !analog_o.buffer_bypass && analog_o.modulator_gain == 2'h0;
  endproperty
  a_sup_rest: assert property (p_sup_rest) else $error("supply bypass or gain wrong");

  property p_duty_rest;
    duty_mode |=> analog_o.regulator_enable == $past(duty_power) && !analog_o.sample_rate_select
      && !analog_o.buffer_bypass && !analog_o.modulator_current_boost;
  endproperty
  a_duty_rest: assert property (p_duty_rest) else $error("duty forced bits wrong");

endmodule : afe_cfg_regs

// *** design/afe_duty_seq.sv ***
`timescale 1ns/1ps

module afe_duty_seq
  import afe_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = 156250,
  parameter int unsigned ON_CYC = 20000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  output logic power_o
);

  afe_dc_state_t state_reg;
  logic [31:0] cnt_reg;

  // counter restarts each period and runs on through both phases; run low parks the sequencer off
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      state_reg <= AFE_DC_IDLE;
      cnt_reg <= 32'h0;
    end else begin
      case (state_reg)
        AFE_DC_IDLE: begin
          state_reg <= AFE_DC_ON;
          cnt_reg <= 32'h0;
        end
        AFE_DC_ON: begin
          if (cnt_reg == ON_CYC - 1) begin
            state_reg <= AFE_DC_OFF;
          end
          cnt_reg <= cnt_reg + 32'h1;
        end
        AFE_DC_OFF: begin
          if (cnt_reg == PERIOD_CYC - 1) begin
            state_reg <= AFE_DC_ON;
            cnt_reg <= 32'h0;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        default: begin
          state_reg <= AFE_DC_IDLE;
        end
      endcase
    end
  end

  assign power_o = (state_reg == AFE_DC_ON);

endmodule : afe_duty_seq

// *** design/afe_pkg.sv ***
package afe_pkg;

  typedef struct packed {
    logic vref_enable;
    logic converter_enable;
    logic regulator_enable;
    logic modulator_current_boost;
    logic sample_rate_select;
    logic [2:0] neg_input_select;
    logic [2:0] pos_input_select;
    logic [2:0] output_rate_select;
    logic buffer_bypass;
    logic [1:0] amp_gain;
    logic [1:0] modulator_gain;
    logic level_shift_enable;
    logic [1:0] reference_select;
  } afe_analog_t;

  typedef struct packed {
    logic hit;
    logic wr;
    logic [2:0] idx;
    logic [7:0] wdata;
  } afe_req_t;

  typedef enum logic [1:0] {AFE_DC_IDLE, AFE_DC_ON, AFE_DC_OFF} afe_dc_state_t;

endpackage : afe_pkg

// *** design/afe_wb_slave.sv ***
`timescale 1ns/1ps
`include "afe_cfg.svh"

module afe_wb_slave
  import afe_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // register side
  output afe_req_t req_o,
  input wire logic [7:0] rdata_i
);

  logic req_live;

  // ack one cycle after the request, dropped the cycle after
  assign req_live = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_comb begin
    req_o.idx = wb_adr_i[4:2];
    req_o.hit = (wb_adr_i[7:5] == 3'h0) && (wb_adr_i[1:0] == 2'h0);
    req_o.wr = req_live && wb_we_i && wb_sel_i[0] && req_o.hit;
    req_o.wdata = wb_dat_i[7:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req_live;
    end
  end

  // unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (req_live && !wb_we_i) begin
      wb_dat_o <= {24'h0, rdata_i};
    end
  end

endmodule : afe_wb_slave

// *** sim/afe_host_model.sv ***
`timescale 1ns/1ps

module afe_host_model (
  // clock
  input wire logic clk_i,
  // wishbone master
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i
);
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end

  // one classic cycle; idle address and data lines are inverted so stale values never pass
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                      input logic [31:0] wdat, output logic [31:0] rdat);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_sel_o <= sel;
    wb_dat_o <= wdat;
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    rdat = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
    wb_adr_o <= ~adr;
    wb_sel_o <= 4'h0;
    wb_dat_o <= ~wdat;
  endtask : xfer
endmodule : afe_host_model

// *** sim/tb.sv ***
`timescale 1ns/1ps
`include "afe_cfg.svh"

module tb
  import afe_pkg::*;
();
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r;
  afe_analog_t analog;
  int num_errors = 0;
  int compares = 0;

  always #5 clk_i = ~clk_i;

  // short duty period keeps the run brief
  afe_cfg_regs #(.DUTY_PERIOD_CYC(40), .DUTY_ON_CYC(10)) i_afe_cfg_regs (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
    .wb_ack_o(wb_ack), .analog_o(analog));

  afe_host_model i_afe_host_model (
    .clk_i(clk_i), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we),
    .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_dat_w), .wb_ack_i(wb_ack),
    .wb_dat_i(wb_dat_r));

  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_an(input afe_analog_t got, input afe_analog_t exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_an

  task automatic wr(input logic [7:0] adr, input logic [3:0] sel, input logic [7:0] d);
    logic [31:0] unused;
    i_afe_host_model.xfer(1'b1, adr, sel, {24'h0, d}, unused);
  endtask : wr

  task automatic rd(input logic [7:0] adr, output logic [31:0] d);
    i_afe_host_model.xfer(1'b0, adr, 4'hF, 32'h0, d);
  endtask : rd

  // expected effective settings; supply mode wins over work mode
  function automatic afe_analog_t model(input logic [7:0] s, input logic [7:0] i,
                                        input logic [7:0] g);
    afe_analog_t m;
    m = {s[3:1], i, g, 3'h0};
    if (s[7:6] == `AFE_MSEL_SUPPLY) begin
      m.vref_enable = 1'b1;
      m.neg_input_select = `AFE_SUP_INSEL;
      m.pos_input_select = `AFE_SUP_INSEL;
      m.amp_gain = 2'h0;
      m.buffer_bypass = 1'b0;
      m.modulator_gain = 2'h0;
      m.reference_select = `AFE_SUP_REFSEL;
      m.sample_rate_select = 1'b0;
      m.modulator_current_boost = 1'b0;
    end else if (s[7:6] == `AFE_MSEL_MANUAL && s[5:4] != `AFE_WMODE_FREE) begin
      m.sample_rate_select = (s[5:4] == `AFE_WMODE_HIPERF);
      m.buffer_bypass = (s[5:4] == `AFE_WMODE_COMMON);
      m.modulator_current_boost = (s[5:4] == `AFE_WMODE_HIPERF);
    end
    return m;
  endfunction : model

  task automatic apply(input logic [7:0] s, input logic [7:0] i, input logic [7:0] g);
    logic [31:0] r;
    wr(8'h00, 4'hF, s);
    wr(8'h04, 4'hF, i);
    wr(8'h08, 4'hF, g);
    repeat (3) @(posedge clk_i);
    #1;
    chk_an(analog, model(s, i, g));
    rd(8'h00, r);
    chk_word(r, {24'h0, s});
    rd(8'h04, r);
    chk_word(r, {24'h0, i});
    rd(8'h08, r);
    chk_word(r, {24'h0, g});
  endtask : apply

  task automatic t_reset();
    logic [31:0] r;
    for (int k = 0; k < 4; k++) begin
      rd(8'(k * 4), r);
      chk_word(r, 32'h0);
    end
    chk_an(analog, model(8'h00, 8'h00, 8'h00));
  endtask : t_reset

  task automatic t_free();
    apply(8'h3E, 8'hAB, 8'hE7);
    apply(8'h31, 8'h54, 8'h1A);
  endtask : t_free

  task automatic t_modes();
    apply(8'h86, 8'hFF, 8'hFF);
    apply(8'h50, 8'h00, 8'h10);
    apply(8'hF0, 8'h40, 8'h00);
    apply(8'h18, 8'h3F, 8'h10);
    apply(8'h08, 8'hC0, 8'h00);
  endtask : t_modes

  task automatic t_duty();
    int on_conv;
    int on_regu;
    on_conv = 0;
    on_regu = 0;
    wr(8'h04, 4'hF, 8'hC0);
    wr(8'h08, 4'hF, 8'h10);
    wr(8'h00, 4'hF, 8'h26);
    repeat (50) @(posedge clk_i);
    repeat (40) begin
      @(posedge clk_i);
      #1;
      on_conv += analog.converter_enable;
      on_regu += analog.regulator_enable;
    end
    chk_word(32'(on_conv), 32'h0000000A);
    chk_word(32'(on_regu), 32'h0000000A);
    chk_word({29'h0, analog.output_rate_select}, {29'h0, `AFE_DUTY_ORATE});
    chk_word({29'h0, analog.sample_rate_select, analog.buffer_bypass,
              analog.modulator_current_boost}, 32'h0);
    apply(8'h30, 8'h00, 8'h00);
  endtask : t_duty

  task automatic t_spare();
    logic [31:0] r;
    wr(8'h0C, 4'hF, 8'hA5);
    wr(8'h0C, 4'hE, 8'hFF);
    wr(8'h0D, 4'hF, 8'h00);
    rd(8'h0C, r);
    chk_word(r, 32'hA5);
    wr(8'h1C, 4'hF, 8'hFF);
    rd(8'h1C, r);
    chk_word(r, 32'h0);
  endtask : t_spare

  // level shift and reference live outside the first four registers
  task automatic t_aux();
    logic [31:0] r;
    rd(8'h14, r);
    chk_word(r, 32'h40);
    wr(8'h10, 4'hF, 8'h04);
    wr(8'h14, 4'hF, 8'h4C);
    wr(8'h00, 4'hF, 8'h30);
    repeat (3) @(posedge clk_i);
    #1;
    chk_word({29'h0, analog.level_shift_enable, analog.reference_select}, 32'h7);
    wr(8'h00, 4'hF, 8'h80);
    wr(8'h18, 4'hF, 8'hFF);
    rd(8'h18, r);
    chk_word(r, 32'h2);
    #1;
    chk_word({29'h0, analog.level_shift_enable, analog.reference_select}, 32'h2);
  endtask : t_aux

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_free();
    t_modes();
    t_duty();
    t_spare();
    t_aux();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    stop_test();
  end
endmodule : tb
